/* File: rtl/ppl_linearizer.v */
// Position post-processing: zero/slope calibration, then piecewise-linear correction
// through nine fixed points, with the results readable over classic Wishbone.
// Assumes raw samples come from the arctan stage on the same clock and that the analog
// output driver takes linearized samples with a valid/ready handshake.
`timescale 1ns/100ps
`include "ppl_consts.vh"

module ppl_linearizer #(
	parameter FIFO_DEPTH = `PPL_FIFO_DEPTH,
	parameter FIFO_AW = `PPL_FIFO_AW
) (
	// Clock and reset.
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave.
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output wire wb_ack_o,
	// Raw samples from the angle stage.
	input wire raw_valid_i,
	input wire [15:0] raw_data_i,
	output wire raw_ready_o,
	// Linearized samples to the output driver.
	output wire lin_valid_o,
	output wire [15:0] lin_data_o,
	input wire lin_ready_i
);

	// Each sample takes four cycles through the sequencer: one to leave the buffer,
	// one to calibrate, one to linearize and at least one to hand over. The driver
	// therefore sees at most one result every four cycles, far faster than the angle
	// stage delivers new positions.
	// Processing states.
	localparam [1:0] S_IDLE = 2'b00;
	localparam [1:0] S_CAL = 2'b01;
	localparam [1:0] S_LIN = 2'b10;
	localparam [1:0] S_OUT = 2'b11;

	// The configuration words stand in for the nonvolatile store and are loaded over
	// the bus after reset. A write that lands while a sample is in flight acts on that
	// sample from its next step on, so software should change trims only while the
	// stream is idle.
	// Configuration words.
	reg [15:0] zero_offset;
	reg [15:0] slope;
	reg [15:0] trim_word [0:4];

	// Datapath registers.
	reg [1:0] state;
	reg [15:0] raw_position;
	reg [15:0] calibrated_position;
	reg [15:0] linearized_position;
	reg lin_valid;

	// Bus registers.
	reg wb_ack;
	reg [31:0] wb_dat;
	reg [31:0] next_rd_word;

	// Buffer connections.
	wire fifo_valid;
	wire [15:0] fifo_data;
	wire [FIFO_AW:0] fifo_level;
	wire fifo_take = (state == S_IDLE);

	// Trims after range limiting, nine bytes packed low to high.
	wire [71:0] trim_all;

	// The buffer absorbs bursts from the angle stage while the driver stalls us.
	ppl_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(raw_valid_i),
		.in_data_i(raw_data_i),
		.in_ready_o(raw_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(fifo_take),
		.level_o(fifo_level)
	);

	// Trim k sits in word k/2, low byte when k is even, high byte when odd.
	genvar k;
	generate
		for (k = 0; k < 9; k = k + 1) begin : g_trim
			wire [7:0] trim_byte = trim_word[k/2][(k%2)*8 +: 8];
			// The most negative byte would exceed the symmetric range, so pull it in.
			assign trim_all[k*8 +: 8] = (trim_byte == `PPL_TRIM_NEG_RAW) ?
				`PPL_TRIM_NEG_MIN : trim_byte;
		end
	endgenerate

	// The product is kept at full width so that a slope of up to four never loses
	// high bits before the saturation test.
	// Calibration: subtract the zero offset modulo one turn, then scale.
	wire [15:0] cal_diff = raw_position - zero_offset;
	wire [15:0] slope_eff = (slope > `PPL_SLOPE_MAX) ? `PPL_SLOPE_MAX : slope;
	wire [31:0] cal_prod = cal_diff * slope_eff;
	wire [21:0] cal_scaled = cal_prod[31:`PPL_SLOPE_FRAC];
	// A slope above one can push past full scale, so the result is held at the top.
	wire [15:0] cal_next = (|cal_scaled[21:16]) ? `PPL_POS_MAX : cal_scaled[15:0];

	// Section and weight come straight from the calibrated value, so x is untouched.
	wire [2:0] seg = calibrated_position[`PPL_SEG_MSB:`PPL_SEG_LSB];
	wire [12:0] wgt = calibrated_position[`PPL_WGT_MSB:0];
	wire [3:0] seg_hi = {1'b0, seg} + 4'h1;

	// Trims at the section's lower and upper edges; points sit at seg * 8192.
	wire signed [7:0] trim_lo = trim_all[{seg, 3'b000} +: 8];
	wire signed [7:0] trim_hi = trim_all[{seg_hi, 3'b000} +: 8];

	// The lower weight runs from 8192 down to 1 and the upper from 0 up to 8191, so
	// a position exactly on a point takes that point's trim alone and the blend
	// moves smoothly from one point to the next.
	// Weights of the two edges; they always sum to one section.
	wire [13:0] wgt_lo_u = `PPL_SECTION - {1'b0, wgt};
	wire signed [14:0] wgt_lo = {1'b0, wgt_lo_u};
	wire signed [14:0] wgt_hi = {2'b00, wgt};

	// Linear blend of the two trims, in units of 1/8192 trim step.
	wire signed [22:0] part_lo = trim_lo * wgt_lo;
	wire signed [22:0] part_hi = trim_hi * wgt_hi;
	wire signed [23:0] blend = {part_lo[22], part_lo} + {part_hi[22], part_hi};

	// One trim step is 32 position counts; dividing by 8192 and scaling by 32 is a
	// single shift. Rounding is toward minus infinity, at most one count of bias.
	wire signed [23:0] corr = blend >>> `PPL_INTERP_SH;

	// A negative sum can only come from a negative trim near zero, and a sum above
	// full scale only from a positive trim near the top, so the two clamps never
	// meet.
	// Correction acts on the y value only and the sum is clamped to the 16-bit range.
	wire signed [24:0] lin_sum = $signed({9'h000, calibrated_position}) +
		$signed({corr[23], corr});
	wire [15:0] lin_next = lin_sum[24] ? 16'h0000 :
		((|lin_sum[23:16]) ? `PPL_POS_MAX : lin_sum[15:0]);

	// Sample sequencer: one sample at a time, raw, then calibrated, then linearized.
	// Holding in S_OUT until the driver accepts is what lets the buffer fill.
	always @(posedge clk_i) begin
		if (rst_i) begin
			state <= S_IDLE;
			raw_position <= 16'h0000;
			calibrated_position <= 16'h0000;
			linearized_position <= 16'h0000;
			lin_valid <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					if (fifo_valid) begin
						raw_position <= fifo_data;
						state <= S_CAL;
					end
				end
				S_CAL: begin
					calibrated_position <= cal_next;
					state <= S_LIN;
				end
				S_LIN: begin
					// Built from the calibrated register, never from the raw sample.
					linearized_position <= lin_next;
					lin_valid <= 1'b1;
					state <= S_OUT;
				end
				S_OUT: begin
					if (lin_ready_i) begin
						lin_valid <= 1'b0;
						state <= S_IDLE;
					end
				end
				default: begin
					lin_valid <= 1'b0;
					state <= S_IDLE;
				end
			endcase
		end
	end

	assign lin_valid_o = lin_valid;
	assign lin_data_o = linearized_position;

	// Byte-lane merge for the 16-bit configuration words; upper lanes are ignored.
	function [15:0] ppl_merge;
		input [15:0] old;
		input [31:0] data;
		input [3:0] sel;
		begin
			ppl_merge = old;
			if (sel[0]) begin
				ppl_merge[7:0] = data[7:0];
			end
			if (sel[1]) begin
				ppl_merge[15:8] = data[15:8];
			end
		end
	endfunction

	// Only the word index and bit 7 are decoded; the two byte-offset bits are ignored, so any
	// byte address inside a word reaches that word.
	// Bus decode: word index from address bits 6..2, bit 7 must be clear.
	wire [4:0] wb_idx = wb_adr_i[6:2];
	wire wb_in_map = ~wb_adr_i[7];
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack;
	// A write lands on the edge where the master samples the acknowledge.
	wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack & wb_in_map;
	wire wb_trim = (wb_idx >= `PPL_IDX_TRIM_FIRST) && (wb_idx <= `PPL_IDX_TRIM_LAST);
	wire [2:0] wb_trim_sel = wb_idx[2:0] - 3'h3;

	// Read mux; unmapped and reserved indices read as zero.
	always @* begin
		next_rd_word = 32'h00000000;
		if (wb_in_map) begin
			case (wb_idx)
				`PPL_IDX_ZERO: next_rd_word = {16'h0000, zero_offset};
				`PPL_IDX_SLOPE: next_rd_word = {16'h0000, slope};
				`PPL_IDX_RAW: next_rd_word = {16'h0000, raw_position};
				`PPL_IDX_CAL: next_rd_word = {16'h0000, calibrated_position};
				`PPL_IDX_LIN: next_rd_word = {16'h0000, linearized_position};
				`PPL_IDX_STATUS: begin
					next_rd_word[FIFO_AW:0] = fifo_level;
					next_rd_word[9:8] = state;
					next_rd_word[10] = lin_valid;
				end
				default: begin
					if (wb_trim) begin
						next_rd_word = {16'h0000, trim_word[wb_trim_sel]};
					end
				end
			endcase
		end
	end

	// Every access is acknowledged one cycle after it is seen, mapped or not.
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack <= 1'b0;
			wb_dat <= 32'h00000000;
		end else begin
			wb_ack <= wb_req;
			if (wb_req) begin
				wb_dat <= next_rd_word;
			end
		end
	end

	assign wb_ack_o = wb_ack;
	assign wb_dat_o = wb_dat;

	// Configuration writes. Result registers ignore writes, which keeps them read-only.
	always @(posedge clk_i) begin
		if (rst_i) begin
			zero_offset <= `PPL_RST_ZERO;
			slope <= `PPL_RST_SLOPE;
			trim_word[0] <= `PPL_RST_TRIM;
			trim_word[1] <= `PPL_RST_TRIM;
			trim_word[2] <= `PPL_RST_TRIM;
			trim_word[3] <= `PPL_RST_TRIM;
			trim_word[4] <= `PPL_RST_TRIM;
		end else if (wb_wr) begin
			if (wb_idx == `PPL_IDX_ZERO) begin
				zero_offset <= ppl_merge(zero_offset, wb_dat_i, wb_sel_i);
			end
			if (wb_idx == `PPL_IDX_SLOPE) begin
				slope <= ppl_merge(slope, wb_dat_i, wb_sel_i);
			end
			if (wb_trim) begin
				trim_word[wb_trim_sel] <= ppl_merge(trim_word[wb_trim_sel], wb_dat_i,
					wb_sel_i);
			end
		end
	end

endmodule // ppl_linearizer

/* File: inc/ppl_consts.vh */
// Constants of the piecewise position linearizer: register indices, reset values and
// datapath field positions.
// Assumes a 32-bit Wishbone bus where a register's byte address is four times its index.
`ifndef PPL_CONSTS_VH
`define PPL_CONSTS_VH

// Register indices; the byte address is the index shifted left by two.
`define PPL_IDX_ZERO 5'h00
`define PPL_IDX_SLOPE 5'h01
`define PPL_IDX_TRIM_FIRST 5'h03
`define PPL_IDX_TRIM_LAST 5'h07
`define PPL_IDX_RAW 5'h18
`define PPL_IDX_CAL 5'h19
`define PPL_IDX_LIN 5'h1A
`define PPL_IDX_STATUS 5'h1B

// Reset values of the nonvolatile configuration words.
`define PPL_RST_ZERO 16'h0000
`define PPL_RST_SLOPE 16'h0400
`define PPL_RST_TRIM 16'h0000

// Slope is fixed point with ten fraction bits; 16'h0400 is unity, 16'h1000 is four.
`define PPL_SLOPE_MAX 16'h1000
`define PPL_SLOPE_FRAC 10

// Section index and interpolation weight fields of the calibrated position.
`define PPL_SEG_MSB 15
`define PPL_SEG_LSB 13
`define PPL_WGT_MSB 12
`define PPL_SECTION 14'h2000

// Trim limits; the most negative byte is pulled in to keep the range symmetric.
`define PPL_TRIM_NEG_RAW 8'h80
`define PPL_TRIM_NEG_MIN 8'h81

// Interpolation sum carries 13 weight bits; scaling by 32 leaves a right shift of 8.
`define PPL_INTERP_SH 8
`define PPL_POS_MAX 16'hFFFF

// Input buffer geometry.
`define PPL_FIFO_DEPTH 32
`define PPL_FIFO_AW 5

`endif

/* File: rtl/ppl_fifo.v */
// Synchronous FIFO that buffers raw position samples ahead of the linearizer.
// Assumes DEPTH is a power of two equal to 2**AW, one clock and a synchronous reset.
`timescale 1ns/100ps

module ppl_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	// Clock and reset.
	input wire clk_i,
	input wire rst_i,
	// Filling side.
	input wire in_valid_i,
	input wire [WIDTH-1:0] in_data_i,
	output wire in_ready_o,
	// Draining side.
	output wire out_valid_o,
	output wire [WIDTH-1:0] out_data_o,
	input wire out_ready_i,
	// Fill level.
	output wire [AW:0] level_o
);

	localparam [AW:0] FULL = {1'b1, {AW{1'b0}}}; // Equals DEPTH, which must be 2**AW.

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] level;
	reg in_ready;
	reg [AW:0] next_level;

	wire push = in_valid_i & in_ready;
	wire pop = out_valid_o & out_ready_i;

	assign in_ready_o = in_ready;
	assign out_valid_o = (level != {(AW+1){1'b0}});
	assign out_data_o = mem[rd_ptr];
	assign level_o = level;

	// Level after this cycle's push and pop.
	always @* begin
		next_level = level;
		if (push && !pop) begin
			next_level = level + 1'b1;
		end else if (pop && !push) begin
			next_level = level - 1'b1;
		end
	end

	// Ready is registered from the next level so that the source sees a clean flop.
	always @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			level <= {(AW+1){1'b0}};
			in_ready <= 1'b1;
		end else begin
			level <= next_level;
			in_ready <= (next_level != FULL);
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// Storage carries no reset; only entries below the level are ever read.
	always @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

endmodule // ppl_fifo

/* File: testbench/ppl_linearizer_props.sv */
// Checker for the linearizer top: bus answer timing and output stream handshake.
// Assumes it is bound to ppl_linearizer and sees only that module's ports.
`timescale 1ns/100ps

module ppl_linearizer_props (
	// Clock and reset.
	input wire clk_i,
	input wire rst_i,
	// Register bus.
	input wire [7:0] wb_adr_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire [31:0] wb_dat_o,
	// Linearized stream.
	input wire lin_valid_o,
	input wire [15:0] lin_data_o,
	input wire lin_ready_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A taken request is answered on the next edge, once, and never unasked.
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	// Reads outside the map give zero, and the upper half never carries data.
	unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[7]
		|=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	// An offered result stands until taken, then the pipeline needs three edges.
	lin_hold_a: assert property (lin_valid_o && !lin_ready_i |=> lin_valid_o && $stable(lin_data_o))
		else $error("result dropped while stalled");
	lin_drop_a: assert property (lin_valid_o && lin_ready_i |=> !lin_valid_o)
		else $error("result offered twice");
	lin_gap_a: assert property ($fell(lin_valid_o) |-> !lin_valid_o [*3])
		else $error("result skipped a stage");
	reset_quiet_a: assert property ($fell(rst_i) |-> !lin_valid_o && !wb_ack_o)
		else $error("outputs active after reset");
endmodule // ppl_linearizer_props

bind ppl_linearizer ppl_linearizer_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .lin_valid_o(lin_valid_o),
	.lin_data_o(lin_data_o), .lin_ready_i(lin_ready_i));

/* File: testbench/ppl_raw_source.sv */
// Model of the angle stage that feeds raw position words to the linearizer.
// Assumes the bench fills its queue with push and that words are taken on valid and ready.
`timescale 1ns/100ps

module ppl_raw_source (
	// Clock and reset.
	input wire clk_i,
	input wire rst_i,
	// Pacing: when high, idle cycles fall between words.
	input wire slow_i,
	// Stream into the linearizer.
	input wire ready_i,
	output logic valid_o = 1'b0,
	output logic [15:0] data_o = 16'h0000
);
	logic [15:0] q[$];
	task push(input logic [15:0] v);
		q.push_back(v);
	endtask
	// A word is held until taken; after that the lines show the next word or, if none follows at once, its inverse, so no stale copy passes.
	always @(posedge clk_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
		end else begin
			if ((!valid_o || ready_i) && q.size() > 0 && !(slow_i && $urandom % 2)) begin
				valid_o <= 1'b1;
				data_o <= q.pop_front();
			end else if (valid_o && ready_i) begin
				valid_o <= 1'b0;
				data_o <= ~data_o;
			end
		end
	end
endmodule // ppl_raw_source

/* File: testbench/ppl_linearizer_tb.sv */
// Self-checking bench: register map, calibration and piecewise correction against a model.
// Assumes the raw source model and the bound checker are compiled alongside.
`timescale 1ns/100ps

module ppl_linearizer_tb;
	reg clk_i = 0;
	reg rst_i = 1;
	reg [7:0] wb_adr_i = 8'h00;
	reg [31:0] wb_dat_i = 32'h0;
	reg [3:0] wb_sel_i = 4'hF;
	logic [3:0] sel_n = 4'hF;
	reg wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, lin_ready_i = 0, stall = 0, slow = 0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, raw_valid_i, raw_ready_o, lin_valid_o;
	wire [15:0] raw_data_i, lin_data_o;
	int n_fail = 0, tests_run = 0, zero, slope, cal, v, l, i, j, k, tr[9], eq[$];
	logic [7:0] tb8[9];
	logic [31:0] q;
	ppl_linearizer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .raw_valid_i(raw_valid_i),
		.raw_data_i(raw_data_i), .raw_ready_o(raw_ready_o), .lin_valid_o(lin_valid_o),
		.lin_data_o(lin_data_o), .lin_ready_i(lin_ready_i));
	ppl_raw_source src (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .ready_i(raw_ready_o),
		.valid_o(raw_valid_i), .data_o(raw_data_i));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// The output driver stalls at random when slow, and wholly while stall is set.
	always @(posedge clk_i) lin_ready_i <= !stall && (!slow || $urandom % 2);
	// Every accepted result is matched, in order, against the model.
	always @(posedge clk_i) begin
		if (!rst_i && lin_valid_o && lin_ready_i) begin
			chk("lin_data", lin_data_o, eq.size() ? eq.pop_front() : -1);
		end
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// One classic cycle; a missing ack ends the run.
	task wb(input logic [7:0] a, input logic we, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_sel_i <= sel_n;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		n = 0;
		do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		if (n >= 20) begin n_fail++; test_done; end
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(a, 0, 32'h0);
		chk(nm, q, e);
	endtask
	// Reference arithmetic with integers; floor division by shifting signed sums.
	function automatic int model(input int raw);
		int c, w, t;
		c = (((raw - zero) & 65535) * (slope > 4096 ? 4096 : slope)) >>> 10;
		cal = c > 65535 ? 65535 : c;
		w = cal & 8191;
		t = cal + ((tr[cal >> 13] * (8192 - w) + tr[(cal >> 13) + 1] * w) >>> 8);
		return t < 0 ? 0 : (t > 65535 ? 65535 : t);
	endfunction
	function automatic logic [31:0] tw(input int n);
		return {16'h0000, n == 4 ? 8'h5A : tb8[2 * n + 1], tb8[2 * n]};
	endfunction
	task send(input int s);
		eq.push_back(model(s));
		src.push(s[15:0]);
	endtask
	task drain;
		int n;
		n = 0;
		while (eq.size() > 0 && n < 3000) begin @(posedge clk_i); n++; end
		if (n >= 3000) begin n_fail++; test_done; end
	endtask
	initial begin
		void'($urandom(90264));
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		rc(8'h00, 32'h0, "zero_rst");
		rc(8'h04, 32'h0400, "slope_rst");
		for (i = 0; i < 5; i++) rc(8'h0C + 4 * i, 32'h0, "trim_rst");
		wb(8'h08, 1, 32'hFFFF);
		rc(8'h08, 32'h0, "unmapped");
		rc(8'h8C, 32'h0, "high_adr");
		// A write with only the low lane enabled leaves the high byte at its old value.
		sel_n = 4'h1;
		wb(8'h00, 1, 32'h0000ABCD);
		sel_n = 4'hF;
		rc(8'h00, 32'h000000CD, "sel_merge");
		// Four setups: unity, random, a -128 coded trim, and a slope above four.
		for (k = 0; k < 4; k++) begin
			zero = k == 0 ? 0 : $urandom % 65536;
			slope = k == 0 ? 1024 : (k == 3 ? 16'h1FFF : 512 + $urandom % 3585);
			for (i = 0; i < 9; i++) begin
				tb8[i] = (k == 2 && i == 4) ? 8'h80 : 8'($urandom % 255 + 129);
				tr[i] = tb8[i] == 8'h80 ? -127 : int'($signed(tb8[i]));
			end
			wb(8'h00, 1, zero);
			wb(8'h04, 1, slope);
			for (i = 0; i < 5; i++) wb(8'h0C + 4 * i, 1, tw(i));
			for (i = 0; i < 5; i++) rc(8'h0C + 4 * i, tw(i), "trim");
			rc(8'h04, slope, "slope");
			v = $urandom % 65536;
			send(v);
			drain;
			l = model(v);
			rc(8'h60, v, "raw");
			rc(8'h64, cal, "cal");
			rc(8'h68, l, "lin");
			wb(8'h64, 1, ~cal);
			rc(8'h64, cal, "cal_ro");
			// Section edges in the unity setup (zero plus multiples of 8192 elsewhere) and random words, with stalls when slow.
			slow <= k[0];
			for (j = 0; j < 9; j++) send(zero + j * 8192 - (j == 8));
			repeat (20) send($urandom % 65536);
			drain;
		end
		// Fill the buffer against a stalled driver until it refuses.
		slow <= 0;
		stall <= 1;
		repeat (40) send($urandom % 65536);
		repeat (80) @(posedge clk_i);
		chk("raw_ready", raw_ready_o, 32'h0);
		rc(8'h6C, 32'h0720, "status");
		stall <= 0;
		drain;
		// A reset in mid-run clears the results and restores the configuration.
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk("rst_lin", lin_data_o, 32'h0);
		chk("rst_valid", lin_valid_o, 32'h0);
		chk("rst_ready", raw_ready_o, 32'h1);
		rc(8'h04, 32'h0400, "slope_rerst");
		test_done;
	end
endmodule // ppl_linearizer_tb
